// >>> vmps_host_model.sv
// Host-side model: system power logic, slew oscillator and regulation sense
module vmps_host_model (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic enable_i,
   input  wire logic pg_drop_i,
   input  wire logic out_bad_i,
   input  wire logic slow_i,
   output logic      shutdown_n_o,
   output logic      sys_pg_o,
   output logic      slew_clk_o,
   output logic      in_reg_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Slew oscillator, free running like the resistor-set original
   // ----------------------------------------
   logic [7:0] half_cnt;
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         half_cnt   <= 8'h00;
         slew_clk_o <= 1'b0;
      end else if (half_cnt >= (slow_i ? 8'h4d : 8'h07)) begin
         half_cnt   <= 8'h00;
         slew_clk_o <= ~slew_clk_o;
      end else begin
         half_cnt <= half_cnt + 8'h01;
      end
   end
   // ----------------------------------------
   // System power logic
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      shutdown_n_o <= rstn_i & enable_i;
      sys_pg_o     <= ~pg_drop_i;
      in_reg_o     <= ~out_bad_i & ~pg_drop_i;
   end
endmodule

// >>> vmps_pkg.sv
// Package: constants and types for the mode and power sequencer
package vmps_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int VID_W = 6;
   localparam int TGT_W = 8;
   localparam int OFS_W = 8;
   localparam int CNT_W = 8;
   // ----------------------------------------
   // Slew-clock counts
   // ----------------------------------------
   localparam int DISABLE_TICKS  = 32;
   localparam int SKIP_TICKS     = 32;
   localparam int SKIP_TICKS_ALT = 30;
   // Slew oscillator range, informative only (resistor set, outside this logic)
   localparam int SLEW_NOM_KHZ = 320;
   localparam int SLEW_MIN_KHZ = 64;
   localparam int SLEW_MAX_KHZ = 640;
   // ----------------------------------------
   // Power-up delay
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int PU_DELAY_NS   = 3000000;
   localparam int PU_DELAY_CYC  = (PU_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PU_W          = 16;
   // ----------------------------------------
   // Four-level pin codes and switching frequency
   // ----------------------------------------
   localparam logic [1:0] LVL_GND  = 2'h0;
   localparam logic [1:0] LVL_REF  = 2'h1;
   localparam logic [1:0] LVL_OPEN = 2'h2;
   localparam logic [1:0] LVL_VCC  = 2'h3;
   localparam logic [9:0] FSW_GND_KHZ  = 10'h3e8;
   localparam logic [9:0] FSW_REF_KHZ  = 10'h226;
   localparam logic [9:0] FSW_OPEN_KHZ = 10'h12c;
   localparam logic [9:0] FSW_VCC_KHZ  = 10'h0c8;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_OFF  = 2'b00,
      ST_BOOT = 2'b01,
      ST_RUN  = 2'b10,
      ST_DOWN = 2'b11
   } vmps_state_t;

   typedef struct packed {
      logic             shutdown_n;
      logic             sys_pg;
      logic             deep_sleep_n;
      logic             suspend_select;
      logic             in_reg;
      logic             amp_near_vcc;
      logic             slew_clk;
      logic [1:0]       on_time;
      logic [VID_W-1:0] susp;
      logic [VID_W-1:0] boot;
      logic [VID_W-1:0] vid;
      logic [OFS_W-1:0] ofs_plus;
      logic [OFS_W-1:0] ofs_minus;
   } vmps_pins_t;
endpackage

// >>> vmps_sequencer.sv
// Module: mode select, target slewing, driver disable, fault and power-good logic
// Function
// - Deep-sleep low adds plus-minus offset to the target.
// - After deep-sleep settle, 32 slew ticks then driver disable low, later skip.
// - Suspend slews to suspend level; disable after 32 ticks, skip 32 later.
// - The second delay, disable to skip, is a parameter.
// - Driver disable is a logic output, low parks slave drivers.
// - Voltage-ID is six bits, bit 0 least significant, no pull-ups.
// - In run without suspend the target follows the voltage-ID code; off and ramp-down take zero.
// - Suspend high takes target from the three four-level suspend pins.
// - Boot mode takes target from the three four-level boot pins.
// - Low-side gate forced high when powered down or on fault.
// - Falling system power-good shuts down and sets the fault latch.
// - After transitions, in regulation, power-good is released.
// - Power-good is held high while slewing in run, held low while slewing in boot.
// - Power-good is held low while shut down.
// - Power-good follows system power-good, with 3ms power-up delay.
// - Clock enable asserted in run while slewing, or with system good and output in regulation.
// - Clock enable held low during voltage transitions in run, high during boot.
// - Slew clock from resistor oscillator, 64kHz to 640kHz.
// - On-time pin decodes to 1000, 550, 300 or 200kHz.
// - Amplifier inverting input near supply disables the amplifier.
// - Shutdown ramps the target down at the slew rate.
module vmps_sequencer #(
   parameter int SKIP_TICKS   = vmps_pkg::SKIP_TICKS,
   parameter int PU_DELAY_CYC = vmps_pkg::PU_DELAY_CYC
) (
   input  wire logic                       CLK_SYS_I,
   input  wire logic                       RSTN_I,
   input  wire logic                       SHUTDOWN_N_I,
   input  wire logic                       SYSTEM_POWER_GOOD_IN_I,
   input  wire logic                       DEEP_SLEEP_N_I,
   input  wire logic                       SUSPEND_SELECT_I,
   input  wire logic                       FEEDBACK_IN_REG_I,
   input  wire logic                       AMP_INV_NEAR_VCC_I,
   input  wire logic                       SLEW_CLK_I,
   input  wire logic [1:0]                 ON_TIME_SELECT_I,
   input  wire logic [vmps_pkg::VID_W-1:0] SUSPEND_CODE_PINS_I,
   input  wire logic [vmps_pkg::VID_W-1:0] BOOT_CODE_PINS_I,
   input  wire logic [vmps_pkg::VID_W-1:0] VID_CODE_I,
   input  wire logic [vmps_pkg::OFS_W-1:0] OFFSET_PLUS_I,
   input  wire logic [vmps_pkg::OFS_W-1:0] OFFSET_MINUS_I,
   output logic      [vmps_pkg::TGT_W-1:0] TARGET_O,
   output logic                            DRIVER_DISABLE_N_O,
   output logic                            SKIP_ALLOW_O,
   output logic                            LOW_SIDE_GATE_O,
   output logic                            REG_PGOOD_OUT_O,
   output logic                            REG_PGOOD_OE_O,
   output logic                            CLOCK_ENABLE_N_O,
   output logic                            FAULT_O,
   output logic      [9:0]                 SWITCH_FREQ_KHZ_O,
   output logic                            AMP_ENABLE_O
);
   localparam int TOTAL = vmps_pkg::DISABLE_TICKS + SKIP_TICKS;

   vmps_pkg::vmps_pins_t  raw, s1, s2, s3, pin;
   vmps_pkg::vmps_state_t state;
   logic                       tick_prev, pg_prev, fault, slewing, tick, restart;
   logic                       lp_req;
   logic [vmps_pkg::TGT_W-1:0] target, goal, vid_tgt, goal_prev;
   logic [vmps_pkg::CNT_W-1:0] lp_cnt;
   logic [vmps_pkg::PU_W-1:0]  pu_cnt;
   logic [1:0]                 mode_prev;
   logic                       pu_done;

   // Offset sum clamped into the target range
   function automatic logic [vmps_pkg::TGT_W-1:0] add_ofs(
      input logic [vmps_pkg::VID_W-1:0] v,
      input logic [vmps_pkg::OFS_W-1:0] p,
      input logic [vmps_pkg::OFS_W-1:0] m);
      logic signed [10:0] s;
      s = $signed({5'h00, v}) + $signed({3'h0, p}) - $signed({3'h0, m});
      if (s < 0) return '0;
      if (s > 11'sh0ff) return '1;
      return s[vmps_pkg::TGT_W-1:0];
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   assign raw = '{SHUTDOWN_N_I, SYSTEM_POWER_GOOD_IN_I, DEEP_SLEEP_N_I, SUSPEND_SELECT_I,
                  FEEDBACK_IN_REG_I, AMP_INV_NEAR_VCC_I, SLEW_CLK_I, ON_TIME_SELECT_I,
                  SUSPEND_CODE_PINS_I, BOOT_CODE_PINS_I, VID_CODE_I, OFFSET_PLUS_I,
                  OFFSET_MINUS_I};

   // A bit changes only once stages two and three agree
   always_ff @(posedge CLK_SYS_I) begin
      if (!RSTN_I) begin
         s1  <= '0;
         s2  <= '0;
         s3  <= '0;
         pin <= '0;
      end else begin
         s1  <= raw;
         s2  <= s1;
         s3  <= s2;
         pin <= (s3 & ~(s2 ^ s3)) | (pin & (s2 ^ s3));
      end
   end

   // Slew clock edge becomes a one-cycle tick
   always_ff @(posedge CLK_SYS_I) begin
      if (!RSTN_I) begin
         tick_prev <= 1'b0;
         pg_prev   <= 1'b0;
      end else begin
         tick_prev <= pin.slew_clk;
         pg_prev   <= pin.sys_pg;
      end
   end
   assign tick = pin.slew_clk & ~tick_prev;

   // ----------------------------------------
   // Target selection
   // ----------------------------------------
   always_comb begin
      vid_tgt = pin.deep_sleep_n ? {2'h0, pin.vid}
              : add_ofs(pin.vid, pin.ofs_plus, pin.ofs_minus);
      unique case (state)
         vmps_pkg::ST_BOOT: goal = {2'h0, pin.boot};
         vmps_pkg::ST_RUN:  goal = pin.suspend_select ? {2'h0, pin.susp} : vid_tgt;
         vmps_pkg::ST_OFF, vmps_pkg::ST_DOWN: goal = '0;
      endcase
   end
   assign slewing = (target != goal);

   // ----------------------------------------
   // Fault latch and state
   // ----------------------------------------
   // Set beats clear, so a fall during a shutdown toggle is kept
   always_ff @(posedge CLK_SYS_I) begin
      if (!RSTN_I) begin
         fault <= 1'b0;
      end else if (pg_prev && !pin.sys_pg) begin
         fault <= 1'b1;
      end else if (!pin.shutdown_n) begin
         fault <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RSTN_I || fault) begin
         state <= vmps_pkg::ST_OFF;
      end else begin
         unique case (state)
            vmps_pkg::ST_OFF: begin
               if (pin.shutdown_n) state <= vmps_pkg::ST_BOOT;
            end
            vmps_pkg::ST_BOOT: begin
               if (!pin.shutdown_n) state <= vmps_pkg::ST_DOWN;
               else if (!slewing && pu_done) state <= vmps_pkg::ST_RUN;
            end
            vmps_pkg::ST_RUN: begin
               if (!pin.shutdown_n) state <= vmps_pkg::ST_DOWN;
            end
            vmps_pkg::ST_DOWN: begin
               if (target == '0) state <= vmps_pkg::ST_OFF;
            end
         endcase
      end
   end

   // One code step per slew tick; a fault drops the target at once
   always_ff @(posedge CLK_SYS_I) begin
      if (!RSTN_I || fault || state == vmps_pkg::ST_OFF) begin
         target <= '0;
      end else if (tick && target < goal) begin
         target <= target + 8'h01;
      end else if (tick && target > goal) begin
         target <= target - 8'h01;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RSTN_I || state == vmps_pkg::ST_OFF) begin
         pu_cnt <= '0;
      end else if (!pu_done) begin
         pu_cnt <= pu_cnt + 16'h0001;
      end
   end
   assign pu_done = (32'(pu_cnt) >= PU_DELAY_CYC);

   // ----------------------------------------
   // Driver disable and pulse skipping
   // ----------------------------------------
   assign lp_req  = (state == vmps_pkg::ST_RUN) && (pin.suspend_select || !pin.deep_sleep_n) && !slewing;
   assign restart = !lp_req || goal != goal_prev
                    || mode_prev != {pin.suspend_select, pin.deep_sleep_n};

   always_ff @(posedge CLK_SYS_I) begin
      if (!RSTN_I) begin
         goal_prev <= '0;
         mode_prev <= 2'h0;
      end else begin
         goal_prev <= goal;
         mode_prev <= {pin.suspend_select, pin.deep_sleep_n};
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RSTN_I || restart) begin
         lp_cnt <= '0;
      end else if (tick && 32'(lp_cnt) < TOTAL) begin
         lp_cnt <= lp_cnt + 8'h01;
      end
   end

   // Disable goes low at 32 ticks, skip after the further parameter count
   always_ff @(posedge CLK_SYS_I) begin
      if (!RSTN_I) begin
         DRIVER_DISABLE_N_O <= 1'b1;
         SKIP_ALLOW_O       <= 1'b0;
      end else begin
         DRIVER_DISABLE_N_O <= restart || 32'(lp_cnt) < vmps_pkg::DISABLE_TICKS;
         SKIP_ALLOW_O       <= !restart && 32'(lp_cnt) >= TOTAL;
      end
   end

   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   // Power-good released only in run: held off through boot and ramp-down
   always_ff @(posedge CLK_SYS_I) begin
      if (!RSTN_I) begin
         REG_PGOOD_OE_O   <= 1'b1;
         CLOCK_ENABLE_N_O <= 1'b1;
         LOW_SIDE_GATE_O  <= 1'b1;
      end else begin
         REG_PGOOD_OE_O <= !(state == vmps_pkg::ST_RUN
                           && (slewing
                               || (pin.in_reg && pin.sys_pg && pu_done)));
         CLOCK_ENABLE_N_O <= !(state == vmps_pkg::ST_RUN
                             && (slewing
                                 || (pin.in_reg && pin.sys_pg && pu_done)));
         LOW_SIDE_GATE_O <= (state == vmps_pkg::ST_OFF) || fault;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RSTN_I) begin
         SWITCH_FREQ_KHZ_O <= vmps_pkg::FSW_GND_KHZ;
         AMP_ENABLE_O      <= 1'b0;
      end else begin
         unique case (pin.on_time)
            vmps_pkg::LVL_GND:  SWITCH_FREQ_KHZ_O <= vmps_pkg::FSW_GND_KHZ;
            vmps_pkg::LVL_REF:  SWITCH_FREQ_KHZ_O <= vmps_pkg::FSW_REF_KHZ;
            vmps_pkg::LVL_OPEN: SWITCH_FREQ_KHZ_O <= vmps_pkg::FSW_OPEN_KHZ;
            vmps_pkg::LVL_VCC:  SWITCH_FREQ_KHZ_O <= vmps_pkg::FSW_VCC_KHZ;
         endcase
         AMP_ENABLE_O <= !pin.amp_near_vcc;
      end
   end

   assign TARGET_O        = target;
   assign FAULT_O         = fault;
   assign REG_PGOOD_OUT_O = 1'b0;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RSTN_I);

   property p_disable_count;
      $fell(DRIVER_DISABLE_N_O) |-> $past(lp_cnt) >= 8'(vmps_pkg::DISABLE_TICKS) && $past(lp_req);
   endproperty
   a_disable_count: assert property (p_disable_count) else $error("disable fell early");

   property p_skip_after_ddo;
      $rose(SKIP_ALLOW_O) |-> !DRIVER_DISABLE_N_O && $past(lp_cnt) >= 8'(TOTAL);
   endproperty
   a_skip_after_ddo: assert property (p_skip_after_ddo) else $error("skip too soon");

   property p_restart;
      state == vmps_pkg::ST_RUN && goal != goal_prev |=> DRIVER_DISABLE_N_O && !SKIP_ALLOW_O;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart on change");

   property p_fault_set;
      pg_prev && !pin.sys_pg |=> fault ##1 LOW_SIDE_GATE_O && state == vmps_pkg::ST_OFF;
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("fault not handled");

   property p_pg_off;
      state == vmps_pkg::ST_OFF |=> REG_PGOOD_OE_O && LOW_SIDE_GATE_O;
   endproperty
   a_pg_off: assert property (p_pg_off) else $error("pgood not low in off");

   property p_slew_flags;
      state == vmps_pkg::ST_RUN && slewing |=> !REG_PGOOD_OE_O && !CLOCK_ENABLE_N_O;
   endproperty
   a_slew_flags: assert property (p_slew_flags) else $error("flags wrong in slew");

   property p_boot_goal;
      state == vmps_pkg::ST_BOOT && !fault && tick && target < {2'h0, pin.boot}
         |=> target == $past(target) + 8'h01;
   endproperty
   a_boot_goal: assert property (p_boot_goal) else $error("boot target wrong");

   property p_sus_goal;
      state == vmps_pkg::ST_RUN && !fault && pin.suspend_select && tick && target != {2'h0, pin.susp}
         |=> (target > $past(target)) == ($past(target) < {2'h0, $past(pin.susp)}) && target != $past(target);
   endproperty
   a_sus_goal: assert property (p_sus_goal) else $error("suspend target wrong");

   property p_ramp;
      state == vmps_pkg::ST_DOWN && !fault |=> target == $past(target) || target == $past(target) - 8'h01;
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp-down too fast");

   c_skip:  cover property (SKIP_ALLOW_O ##1 !SKIP_ALLOW_O);
   c_fault: cover property ($rose(fault));
   c_run:   cover property (state == vmps_pkg::ST_BOOT ##1 state == vmps_pkg::ST_RUN);
endmodule

// >>> vmps_sequencer_tb.sv
// Self-checking testbench of the mode and power sequencer
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module vmps_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P  = 16;
   localparam int SK = vmps_pkg::SKIP_TICKS_ALT;
   logic       clk, rstn, ds_n, susp, near, en, drop, out_bad, slow;
   logic       shut_n, sys_pg, slew, in_reg, drv_dis_n, skip, lsg, pg_out, pg_oe, clk_en_n, fault, amp;
   logic [1:0] ton;
   logic [5:0] scode, bcode, vid;
   logic [7:0] op, om, tgt;
   logic [9:0] fsw;
   logic [31:0] seed, r;
   int         bad_count, total_checks, cycles, i, c;
   vmps_host_model u_vmps_host_model (.clk_i(clk), .rstn_i(rstn), .enable_i(en), .pg_drop_i(drop),
      .out_bad_i(out_bad), .slow_i(slow), .shutdown_n_o(shut_n), .sys_pg_o(sys_pg), .slew_clk_o(slew),
      .in_reg_o(in_reg));
   vmps_sequencer #(.SKIP_TICKS(SK), .PU_DELAY_CYC(20)) u_vmps_sequencer (.CLK_SYS_I(clk), .RSTN_I(rstn),
      .SHUTDOWN_N_I(shut_n), .SYSTEM_POWER_GOOD_IN_I(sys_pg), .DEEP_SLEEP_N_I(ds_n), .SUSPEND_SELECT_I(susp),
      .FEEDBACK_IN_REG_I(in_reg), .AMP_INV_NEAR_VCC_I(near), .SLEW_CLK_I(slew), .ON_TIME_SELECT_I(ton),
      .SUSPEND_CODE_PINS_I(scode), .BOOT_CODE_PINS_I(bcode), .VID_CODE_I(vid), .OFFSET_PLUS_I(op),
      .OFFSET_MINUS_I(om), .TARGET_O(tgt), .DRIVER_DISABLE_N_O(drv_dis_n), .SKIP_ALLOW_O(skip),
      .LOW_SIDE_GATE_O(lsg), .REG_PGOOD_OUT_O(pg_out), .REG_PGOOD_OE_O(pg_oe), .CLOCK_ENABLE_N_O(clk_en_n),
      .FAULT_O(fault), .SWITCH_FREQ_KHZ_O(fsw), .AMP_ENABLE_O(amp));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] goal();
      int t;
      t = int'(vid) + (ds_n ? 0 : int'(op) - int'(om));
      if (susp) return {2'h0, scode};
      return (t < 0) ? 8'h00 : (t > 255) ? 8'hff : t[7:0];
   endfunction
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic endt(input string name);
      $display("test %s done, %0d checks so far", name, total_checks);
   endtask
   // Slewing is checked step by step, so a jump of the target is caught
   task automatic wait_tgt(input logic [7:0] e, input logic run);
      logic [7:0] prev;
      int         k;
      prev = tgt;
      for (k = 0; k < 12000 && tgt !== e; k++) begin
         step();
         if (tgt !== prev) `CHK((tgt - prev == 8'h01) || (prev - tgt == 8'h01), 1'b1)
         if (run && k == 40 && tgt !== e) begin
            `CHK(clk_en_n, 1'b0)
            `CHK(pg_oe, 1'b0)
         end
         prev = tgt;
      end
      `CHK(tgt, e)
   endtask
   task automatic time_to(input logic to_skip, output int n);
      n = 0;
      while (n < 5000 && (to_skip ? skip !== 1'b1 : drv_dis_n !== 1'b0)) begin
         step();
         n++;
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ----------------------------------------
   // Clock and timeout
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         bad_count++;
         give_verdict();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 32'h000031c7;
      {rstn, en, drop, out_bad, slow, susp, near, ton} = 9'h000;
      ds_n  = 1'b1;
      bcode = 6'h1b;
      scode = 6'h0a;
      vid   = 6'h19;
      op    = 8'h09;
      om    = 8'h04;
      repeat (8) step();
      `CHK({tgt, drv_dis_n, skip, lsg, pg_oe, clk_en_n, fault, pg_out}, {8'h00, 7'b1011100})
      rstn = 1'b1;
      en   = 1'b1;
      repeat (10) step();
      `CHK(pg_oe, 1'b1)
      wait_tgt({2'h0, bcode}, 1'b0);
      wait_tgt(goal(), 1'b1);
      repeat (30) step();
      `CHK({pg_oe, clk_en_n}, 2'b00)
      for (i = 0; i < 4; i++) begin
         ton  = i[1:0];
         near = i[0];
         repeat (8) step();
         `CHK(fsw, i == 0 ? vmps_pkg::FSW_GND_KHZ : i == 1 ? vmps_pkg::FSW_REF_KHZ :
                   i == 2 ? vmps_pkg::FSW_OPEN_KHZ : vmps_pkg::FSW_VCC_KHZ)
         `CHK(amp, ~near)
      end
      endt("power-up and decode");
      for (i = 0; i < 5; i++) begin
         r    = rnd();
         slow = (i == 4);
         vid  = (i == 4) ? vid ^ 6'h01 : (i == 0) ? 6'h3f : r[5:0];
         wait_tgt(goal(), 1'b1);
      end
      slow    = 1'b0;
      out_bad = 1'b1;
      repeat (10) step();
      `CHK({pg_oe, clk_en_n}, 2'b11)
      out_bad = 1'b0;
      endt("voltage-id slewing");
      ds_n = 1'b0;
      wait_tgt(goal(), 1'b1);
      time_to(1'b0, c);
      `CHK(c >= 31 * P && c <= 32 * P + 8, 1'b1)
      time_to(1'b1, c);
      `CHK(c >= SK * P - 4 && c <= SK * P + 4, 1'b1)
      vid = vid + 6'h01;
      repeat (8) step();
      `CHK({drv_dis_n, skip}, 2'b10)
      wait_tgt(goal(), 1'b1);
      endt("deep sleep");
      susp  = 1'b1;
      r     = rnd();
      // A code equal to the present target would not slew, so the delay count would start early
      scode = ({2'h0, r[5:0]} == tgt) ? ~r[5:0] : r[5:0];
      wait_tgt({2'h0, scode}, 1'b1);
      time_to(1'b0, c);
      `CHK(c >= 31 * P && c <= 32 * P + 8, 1'b1)
      time_to(1'b1, c);
      `CHK(c >= SK * P - 4 && c <= SK * P + 4, 1'b1)
      endt("suspend");
      drop = 1'b1;
      repeat (12) step();
      `CHK({fault, lsg, pg_oe, tgt}, {3'b111, 8'h00})
      drop = 1'b0;
      repeat (12) step();
      `CHK({fault, lsg}, 2'b11)
      en = 1'b0;
      repeat (12) step();
      `CHK(fault, 1'b0)
      en = 1'b1;
      wait_tgt({2'h0, bcode}, 1'b0);
      susp = 1'b0;
      ds_n = 1'b1;
      wait_tgt(goal(), 1'b1);
      endt("fault and restart");
      en = 1'b0;
      wait_tgt(8'h00, 1'b0);
      repeat (4) step();
      `CHK({lsg, pg_oe}, 2'b11)
      endt("shutdown ramp");
      give_verdict();
   end
endmodule
